//--- hdl/flash_status_config_regs.sv
// status and configuration register bank of a serial multi-line nor flash
`timescale 1ns/1ns
`default_nettype none
`include "flash_regs_consts.svh"

// How it works
// - Status can be read any time, even during a busy cycle.
// - Read-status opcode returns eight status bits on the output; upper lines ignored.
// - Bit 0 is busy while program, erase or status write runs.
// - Bit 1 latch set by write-enable; program and erase ignored while clear.
// - Latch clears when a program or erase finishes.
// - Command into protected area is dropped and clears the latch.
// - Bits 5..2 are protect level, default zero, changed only by status write.
// - Protect level blocks program and erases; chip erase only at level zero.
// - Bit 6 quad enable; when set disables pin functions and hardware protection.
// - Bit 7 lock plus low write-protect pin enters hardware protection.
// - Hardware protection refuses status writes; lock and level become read-only.
// - Config one bit 3 one-time origin select: top at 0, bottom at 1.
// - Config one bit 6 picks dummy cycles 4/6 or 8/10.
// - Config two bit 1 picks low power at 0, high performance at 1.
// - Maker/device id opcode: two dummies, address; address picks which id first.
// - Jedec id returns three bytes repeating until chip select rises, but all zeros during a busy cycle.
// - Status write holds busy for its timed period, then clears busy and latch.
module flash_status_config_regs
   import flash_regs_pkg::*;
#(
   parameter int WSR_CYCLES = `T_WRITE_STATUS_US * `CLK_MHZ,
   parameter int PROGRAM_CYCLES = `T_PROGRAM_US * `CLK_MHZ,
   parameter int ERASE_CYCLES = `T_ERASE_US * `CLK_MHZ,
   // identity values are arbitrary
   parameter logic [7:0] MAKER_ID = 8'hA5,
   parameter logic [7:0] MEM_TYPE = 8'h3C,
   parameter logic [7:0] DENSITY = 8'h5A,
   parameter logic [7:0] DEVICE_ID = 8'h69,
   parameter logic [7:0] SIGNATURE = 8'h96
) (
   // core clock and reset
   input wire logic CLK,
   input wire logic RESETN,
   // serial link
   input wire logic SCLK,
   input wire logic CS_N,
   input wire logic SI,
   input wire logic WP_N,
   output logic SO,
   output logic SO_OE,
   // mode outputs
   output logic BUSY,
   output logic WRITE_ENABLED,
   output logic HW_PROTECT,
   output logic QUAD_IO,
   output logic HIGH_PERF,
   output logic [3:0] DUMMY_DUAL,
   output logic [3:0] DUMMY_QUAD
);
   ctl_state_t state_q, state_d;
   status_t status_q, status_d, status_l;
   cfg1_t cfg1_q, cfg1_d, cfg1_l;
   cfg2_t cfg2_q, cfg2_d, cfg2_l;
   logic [31:0] timer_q, timer_d;
   logic [7:0] op_q, op_d;
   logic [2:0] nbyte_q, nbyte_d;
   logic [7:0] arg_q [3];
   logic [7:0] arg_d [3];
   logic tog_q, tog_d, cs_d1_q, cs_d1_d, cs_d2_q, cs_d2_d;
   logic cs_low_s, tog_s, frag_s, wp_low_s;
   logic [7:0] rx_byte;
   logic byte_tog, frag, byte_evt, exec, hardware_protect_mode, prot_hit, array_op, erase_op, wsr_ok;
   logic [23:0] addr;
   logic [23:0] snap_l;
   logic busy_q, wel_q, hpm_q, quad_q, perf_q;
   logic [3:0] dual_q, quad_dc_q, dual_d, quad_dc_d;

   // ==========================================
   // clock crossings
   // pins pass inverted so cleared sync flops read as idle pins, no false edge after reset
   sync2 #(.W(4)) u_core_sync (
      .clk(CLK),
      .rstn(RESETN),
      .d({~CS_N, byte_tog, frag, ~WP_N}),
      .q({cs_low_s, tog_s, frag_s, wp_low_s})
   );

   // register bits change seldom and only between frames in normal use
   sync2 #(.W(24)) u_link_sync (
      .clk(SCLK),
      .rstn(RESETN),
      .d({status_q, cfg1_q, cfg2_q}),
      .q(snap_l)
   );
   assign {status_l, cfg1_l, cfg2_l} = snap_l;

   link_shifter #(
      .MAKER_ID(MAKER_ID),
      .MEM_TYPE(MEM_TYPE),
      .DENSITY(DENSITY),
      .DEVICE_ID(DEVICE_ID),
      .SIGNATURE(SIGNATURE)
   ) u_link (
      .sclk(SCLK),
      .cs_n(CS_N),
      .rstn(RESETN),
      .si(SI),
      .so(SO),
      .so_oe(SO_OE),
      .status(status_l),
      .cfg1(cfg1_l),
      .cfg2(cfg2_l),
      .rx_byte(rx_byte),
      .byte_tog(byte_tog),
      .frag(frag)
   );

   // ==========================================
   // protected area test
   function automatic logic in_protect(input logic [23:0] a, input logic [3:0] lvl,
      input logic bottom);
      logic [23:0] span;
      logic [23:0] off;
      off = a & (`ARRAY_BYTES - 24'h000001);
      if (lvl == 4'h0)
         span = 24'h000000;
      else if (lvl >= `FULL_LEVEL)
         span = `ARRAY_BYTES;
      else
         span = `PROTECT_UNIT << (lvl - 4'h1);
      if (bottom)
         return off < span;
      return off >= (`ARRAY_BYTES - span);
   endfunction : in_protect

   // ==========================================
   // command decode and register update
   always_comb
   begin
      state_d = state_q;
      status_d = status_q;
      cfg1_d = cfg1_q;
      cfg2_d = cfg2_q;
      timer_d = timer_q;
      op_d = op_q;
      nbyte_d = nbyte_q;
      arg_d = arg_q;
      tog_d = tog_s;
      cs_d1_d = ~cs_low_s;
      cs_d2_d = cs_d1_q;
      byte_evt = tog_s ^ tog_q;
      // cs edge taken one cycle after the byte toggle so the last byte lands first
      exec = cs_d1_q & ~cs_d2_q;
      hardware_protect_mode = status_q.status_write_lock & wp_low_s & ~status_q.quad_io_enable;
      addr = {arg_q[0], arg_q[1], arg_q[2]};
      erase_op = (op_q == `SMALL_AREA_WIPE_CMD) || (op_q == `HALF_BLOCK_WIPE_CMD) ||
         (op_q == `FULL_BLOCK_WIPE_CMD);
      array_op = erase_op || (op_q == `PAGE_PROGRAM_CMD) || (op_q == `CHIP_WIPE_CMD) ||
         (op_q == `CHIP_WIPE_ALT_CMD);
      if ((op_q == `CHIP_WIPE_CMD) || (op_q == `CHIP_WIPE_ALT_CMD))
         prot_hit = (status_q.protect_level != 4'h0);
      else
         prot_hit = in_protect(addr, status_q.protect_level,
            cfg1_q.protect_origin_select);
      wsr_ok = status_q.write_enable_latch && !hardware_protect_mode && !frag_s &&
         (nbyte_q >= `TWO_BYTES) && (nbyte_q <= `FOUR_BYTES);
      if (byte_evt)
      begin
         if (nbyte_q == `NO_BYTES)
            op_d = rx_byte;
         else if (nbyte_q < `FOUR_BYTES)
            arg_d[2'(nbyte_q - 3'h1)] = rx_byte;
         if (nbyte_q != `MAX_BYTES)
            nbyte_d = nbyte_q + 3'h1;
      end
      if (exec)
         nbyte_d = `NO_BYTES;
      case (state_q)
         ST_IDLE:
         begin
            // busy cycles ignore every write-type command
            if (exec && nbyte_q != `NO_BYTES)
            begin
               if (op_q == `WRITE_ENABLE_CMD)
                  status_d.write_enable_latch = 1'b1;
               else if (op_q == `WRITE_DISABLE_CMD)
                  status_d.write_enable_latch = 1'b0;
               else if (op_q == `WRITE_STATUS_CMD && wsr_ok)
               begin
                  status_d.status_write_lock = arg_q[0][7];
                  status_d.quad_io_enable = arg_q[0][6];
                  status_d.protect_level = arg_q[0][5:2];
                  if (nbyte_q >= `ID_ADDR_BYTE)
                  begin
                     cfg1_d.dummy_count_select = arg_q[1][6];
                     cfg1_d.protect_origin_select = cfg1_q.protect_origin_select |
                        arg_q[1][3];
                  end
                  if (nbyte_q == `FOUR_BYTES)
                     cfg2_d.power_select = arg_q[2][1];
                  state_d = ST_WSR;
                  timer_d = 32'(WSR_CYCLES);
               end
               else if (array_op && status_q.write_enable_latch)
               begin
                  if (prot_hit)
                     status_d.write_enable_latch = 1'b0;
                  else
                  begin
                     state_d = ST_ARRAY;
                     timer_d = (op_q == `PAGE_PROGRAM_CMD) ? 32'(PROGRAM_CYCLES) :
                        32'(ERASE_CYCLES);
                  end
               end
            end
         end
         ST_WSR, ST_ARRAY:
         begin
            if (timer_q <= 32'h00000001)
            begin
               state_d = ST_IDLE;
               status_d.write_enable_latch = 1'b0;
            end
            else
               timer_d = timer_q - 32'h00000001;
         end
         default:
            state_d = ST_IDLE;
      endcase
      status_d.write_in_progress_flag = (state_d != ST_IDLE);
      cfg1_d.rsv7 = 1'b0;
      cfg1_d.rsv5_4 = 2'h0;
      cfg1_d.rsv2_0 = 3'h0;
      cfg2_d.rsv7_2 = 6'h00;
      cfg2_d.rsv0 = 1'b0;
      dual_d = cfg1_q.dummy_count_select ? `DUMMY_DUAL_LONG : `DUMMY_DUAL_SHORT;
      quad_dc_d = cfg1_q.dummy_count_select ? `DUMMY_QUAD_LONG : `DUMMY_QUAD_SHORT;
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         state_q <= ST_IDLE;
         status_q <= `STATUS_RESET;
         cfg1_q <= `CONFIG_ONE_RESET;
         cfg2_q <= `CONFIG_TWO_RESET;
         timer_q <= 32'h00000000;
         op_q <= 8'h00;
         nbyte_q <= 3'h0;
         arg_q <= '{default: 8'h00};
         tog_q <= 1'b0;
         cs_d1_q <= 1'b1;
         cs_d2_q <= 1'b1;
         busy_q <= 1'b0;
         wel_q <= 1'b0;
         hpm_q <= 1'b0;
         quad_q <= 1'b0;
         perf_q <= 1'b0;
         dual_q <= `DUMMY_DUAL_SHORT;
         quad_dc_q <= `DUMMY_QUAD_SHORT;
      end
      else
      begin
         state_q <= state_d;
         status_q <= status_d;
         cfg1_q <= cfg1_d;
         cfg2_q <= cfg2_d;
         timer_q <= timer_d;
         op_q <= op_d;
         nbyte_q <= nbyte_d;
         arg_q <= arg_d;
         tog_q <= tog_d;
         cs_d1_q <= cs_d1_d;
         cs_d2_q <= cs_d2_d;
         busy_q <= status_q.write_in_progress_flag;
         wel_q <= status_q.write_enable_latch;
         hpm_q <= hardware_protect_mode;
         quad_q <= status_q.quad_io_enable;
         perf_q <= cfg2_q.power_select;
         dual_q <= dual_d;
         quad_dc_q <= quad_dc_d;
      end
   end

   assign BUSY = busy_q;
   assign WRITE_ENABLED = wel_q;
   assign HW_PROTECT = hpm_q;
   assign QUAD_IO = quad_q;
   assign HIGH_PERF = perf_q;
   assign DUMMY_DUAL = dual_q;
   assign DUMMY_QUAD = quad_dc_q;

   // ==========================================
   // checks
   wel_set_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (exec && state_q == ST_IDLE && nbyte_q != `NO_BYTES && op_q == `WRITE_ENABLE_CMD)
      |=> status_q.write_enable_latch)
      else $error("write enable did not set latch");
   wel_gate_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (state_q == ST_IDLE ##1 state_q == ST_ARRAY) |-> $past(status_q.write_enable_latch))
      else $error("array cycle started without latch");
   done_clear_a: assert property (@(posedge CLK) disable iff (!RESETN)
      $fell(status_q.write_in_progress_flag) |-> !status_q.write_enable_latch)
      else $error("latch still set after busy cycle");
   prot_drop_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (exec && state_q == ST_IDLE && nbyte_q != `NO_BYTES && array_op &&
      status_q.write_enable_latch && prot_hit)
      |=> (state_q == ST_IDLE && !status_q.write_enable_latch))
      else $error("protected command not dropped");
   hpm_hold_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (hardware_protect_mode && exec && state_q == ST_IDLE)
      |=> ($stable(status_q.protect_level) && $stable(status_q.status_write_lock)))
      else $error("status changed under hardware protection");
   origin_otp_a: assert property (@(posedge CLK) disable iff (!RESETN)
      $past(cfg1_q.protect_origin_select) |-> cfg1_q.protect_origin_select)
      else $error("origin select cleared");
   dummy_map_a: assert property (@(posedge CLK) disable iff (!RESETN)
      $changed(cfg1_q.dummy_count_select) |=> (DUMMY_QUAD ==
      ($past(cfg1_q.dummy_count_select) ? `DUMMY_QUAD_LONG : `DUMMY_QUAD_SHORT)))
      else $error("quad dummy count wrong");
   busy_flag_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (state_q == ST_IDLE ##1 state_q != ST_IDLE) |-> status_q.write_in_progress_flag[*2]
      ##1 BUSY)
      else $error("busy flag not raised with cycle");
   rsv_zero_a: assert property (@(posedge CLK) disable iff (!RESETN)
      (cfg1_q.rsv7 == 1'b0 && cfg1_q.rsv5_4 == 2'h0 && cfg1_q.rsv2_0 == 3'h0 &&
      cfg2_q.rsv7_2 == 6'h00 && cfg2_q.rsv0 == 1'b0))
      else $error("reserved config bit set");
   perf_out_a: assert property (@(posedge CLK) disable iff (!RESETN)
      $rose(cfg2_q.power_select) |=> HIGH_PERF)
      else $error("performance mode not shown");
endmodule : flash_status_config_regs
`default_nettype wire

//--- inc/flash_regs_consts.svh
// named constants for the flash status and configuration register bank
`ifndef FLASH_REGS_CONSTS_SVH
`define FLASH_REGS_CONSTS_SVH

// ==========================================
// command opcodes
`define WRITE_STATUS_CMD 8'h01
`define PAGE_PROGRAM_CMD 8'h02
`define WRITE_DISABLE_CMD 8'h04
`define READ_STATUS_CMD 8'h05
`define WRITE_ENABLE_CMD 8'h06
`define READ_CONFIG_CMD 8'h15
`define SMALL_AREA_WIPE_CMD 8'h20
`define HALF_BLOCK_WIPE_CMD 8'h52
`define CHIP_WIPE_CMD 8'h60
`define CHIP_WIPE_ALT_CMD 8'hC7
`define READ_MAKER_DEVICE_ID_CMD 8'h90
`define READ_JEDEC_ID_CMD 8'h9F
`define READ_SIGNATURE_CMD 8'hAB
`define FULL_BLOCK_WIPE_CMD 8'hD8

// ==========================================
// reset values
`define STATUS_RESET 8'h00
`define CONFIG_ONE_RESET 8'h00
`define CONFIG_TWO_RESET 8'h00

// ==========================================
// frame byte counts
`define NO_BYTES 3'h0
`define ONE_BYTE 3'h1
`define TWO_BYTES 3'h2
`define ID_ADDR_BYTE 3'h3
`define FOUR_BYTES 3'h4
`define MAX_BYTES 3'h7
`define LAST_BIT 3'h7
`define JEDEC_LAST 2'h2

// ==========================================
// dummy cycle counts
`define DUMMY_DUAL_SHORT 4'h4
`define DUMMY_DUAL_LONG 4'h8
`define DUMMY_QUAD_SHORT 4'h6
`define DUMMY_QUAD_LONG 4'hA

// ==========================================
// protected area geometry
`define ARRAY_BYTES 24'h040000
`define PROTECT_UNIT 24'h001000
`define FULL_LEVEL 4'h7

// ==========================================
// self-timed cycle lengths
`define CLK_MHZ 50
`define T_WRITE_STATUS_US 4000
`define T_PROGRAM_US 1000
`define T_ERASE_US 40000

`endif

//--- inc/flash_regs_pkg.sv
// types shared by the flash register bank and its serial link
package flash_regs_pkg;

   // ==========================================
   // register layouts
   typedef struct packed {
      logic status_write_lock;
      logic quad_io_enable;
      logic [3:0] protect_level;
      logic write_enable_latch;
      logic write_in_progress_flag;
   } status_t;

   typedef struct packed {
      logic rsv7;
      logic dummy_count_select;
      logic [1:0] rsv5_4;
      logic protect_origin_select;
      logic [2:0] rsv2_0;
   } cfg1_t;

   typedef struct packed {
      logic [5:0] rsv7_2;
      logic power_select;
      logic rsv0;
   } cfg2_t;

   // ==========================================
   // control states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WSR = 3'b010,
      ST_ARRAY = 3'b100
   } ctl_state_t;

endpackage : flash_regs_pkg

//--- hdl/sync2.sv
// two-flop synchroniser for independent level signals
`timescale 1ns/1ns
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] q_d;

   always_comb
   begin
      meta_d = d;
      q_d = meta_q;
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_q <= '0;
         q <= '0;
      end
      else
      begin
         meta_q <= meta_d;
         q <= q_d;
      end
   end
endmodule : sync2
`default_nettype wire

//--- hdl/link_shifter.sv
// serial link end: shifts commands in and register or id bytes out
`timescale 1ns/1ns
`default_nettype none
`include "flash_regs_consts.svh"
module link_shifter
   import flash_regs_pkg::*;
#(
   // identity values are arbitrary
   parameter logic [7:0] MAKER_ID = 8'hA5,
   parameter logic [7:0] MEM_TYPE = 8'h3C,
   parameter logic [7:0] DENSITY = 8'h5A,
   parameter logic [7:0] DEVICE_ID = 8'h69,
   parameter logic [7:0] SIGNATURE = 8'h96
) (
   // link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic rstn,
   input wire logic si,
   output logic so,
   output logic so_oe,
   // register snapshot, already on sclk
   input wire status_t status,
   input wire cfg1_t cfg1,
   input wire cfg2_t cfg2,
   // received bytes toward the core
   output logic [7:0] rx_byte,
   output logic byte_tog,
   output logic frag
);
   logic frame_clr;
   logic [2:0] bit_q, bit_d, nbyte_q, nbyte_d;
   logic [6:0] sh_q, sh_d;
   logic [7:0] op_q, op_d, tx_q, tx_d, tx_now;
   logic addr0_q, addr0_d, so_d, oe_d, byte_done;
   logic [1:0] rot_q, rot_d;
   logic [7:0] rx_d;
   logic tog_d, frag_d;

   assign frame_clr = cs_n | ~rstn;

   // ==========================================
   // byte chosen for output
   function automatic logic [7:0] tx_pick(input logic [7:0] op, input logic [2:0] nb,
      input logic [1:0] rot, input logic a0, input status_t st, input cfg1_t c1,
      input cfg2_t c2);
      logic [7:0] b;
      b = 8'h00;
      if (op == `READ_STATUS_CMD)
         b = st;
      else if (op == `READ_CONFIG_CMD)
         b = rot[0] ? c2 : c1;
      else if (op == `READ_JEDEC_ID_CMD && !st.write_in_progress_flag)
         b = (rot == 2'h0) ? MAKER_ID : ((rot == 2'h1) ? MEM_TYPE : DENSITY);
      else if (op == `READ_MAKER_DEVICE_ID_CMD && nb >= `FOUR_BYTES)
         b = (~rot[0] ^ a0) ? DEVICE_ID : MAKER_ID;
      else if (op == `READ_SIGNATURE_CMD && nb >= `FOUR_BYTES)
         b = SIGNATURE;
      return b;
   endfunction : tx_pick

   // ==========================================
   // rising edge: bit and byte framing
   always_comb
   begin
      byte_done = (bit_q == `LAST_BIT);
      bit_d = bit_q + 3'h1;
      sh_d = {sh_q[5:0], si};
      nbyte_d = nbyte_q;
      op_d = op_q;
      addr0_d = addr0_q;
      rot_d = rot_q;
      rx_d = rx_byte;
      tog_d = byte_tog;
      frag_d = 1'b1;
      if (byte_done)
      begin
         frag_d = 1'b0;
         rx_d = {sh_q, si};
         tog_d = ~byte_tog;
         if (nbyte_q != `MAX_BYTES)
            nbyte_d = nbyte_q + 3'h1;
         if (nbyte_q == `NO_BYTES)
            op_d = {sh_q, si};
         if (nbyte_q == `ID_ADDR_BYTE)
            addr0_d = si;
         if (nbyte_q != `NO_BYTES)
         begin
            if (op_q == `READ_JEDEC_ID_CMD && rot_q == `JEDEC_LAST)
               rot_d = 2'h0;
            else
               rot_d = rot_q + 2'h1;
         end
      end
   end

   // cs high ends the frame and clears framing state
   always_ff @(posedge sclk or posedge frame_clr)
   begin
      if (frame_clr)
      begin
         bit_q <= 3'h0;
         nbyte_q <= 3'h0;
         sh_q <= 7'h00;
         op_q <= 8'h00;
         addr0_q <= 1'b0;
         rot_q <= 2'h0;
      end
      else
      begin
         bit_q <= bit_d;
         nbyte_q <= nbyte_d;
         sh_q <= sh_d;
         op_q <= op_d;
         addr0_q <= addr0_d;
         rot_q <= rot_d;
      end
   end

   // hand-off registers survive cs high so the core can still read them
   always_ff @(posedge sclk or negedge rstn)
   begin
      if (!rstn)
      begin
         rx_byte <= 8'h00;
         byte_tog <= 1'b0;
         frag <= 1'b0;
      end
      else
      begin
         rx_byte <= rx_d;
         byte_tog <= tog_d;
         frag <= frag_d;
      end
   end

   // ==========================================
   // falling edge: serial output
   always_comb
   begin
      tx_now = tx_pick(op_q, nbyte_q, rot_q, addr0_q, status, cfg1, cfg2);
      tx_d = tx_q;
      oe_d = (nbyte_q != `NO_BYTES);
      if (bit_q == 3'h0)
      begin
         tx_d = tx_now;
         so_d = tx_now[7];
      end
      else
         so_d = tx_q[~bit_q];
   end

   always_ff @(negedge sclk or posedge frame_clr)
   begin
      if (frame_clr)
      begin
         tx_q <= 8'h00;
         so <= 1'b0;
         so_oe <= 1'b0;
      end
      else
      begin
         tx_q <= tx_d;
         so <= so_d;
         so_oe <= oe_d;
      end
   end
endmodule : link_shifter
`default_nettype wire

//--- test/flash_host_model.sv
// host side model that drives the serial link of the register bank
`timescale 1ns/1ns
`default_nettype none
module flash_host_model (
   // serial link
   output logic sclk,
   output logic cs_n,
   output logic si,
   input wire logic so,
   // bytes read back
   output logic [7:0] rx,
   output logic rx_tog
);
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si = 1'b0;
      rx = 8'h00;
      rx_tog = 1'b0;
   end
   // ==========================================
   // one byte, msb first; clock stands still between frames
   task automatic shift(input logic [7:0] v, output logic [7:0] b);
      for (int k = 7; k >= 0; k--)
      begin
         si = v[k];
         #7 sclk = 1'b1;
         b[k] = so;
         #8 sclk = 1'b0;
      end
   endtask : shift
   // tx bytes left-justified, then n_rd bytes read
   task automatic frame(input logic [31:0] tx, input int n_tx, input int n_rd);
      logic [7:0] b;
      cs_n = 1'b0;
      #20;
      for (int i = 0; i < n_tx; i++)
         shift(tx[31-8*i -: 8], b);
      for (int i = 0; i < n_rd; i++)
      begin
         // toggling pattern so a device reading it would show
         shift(8'h55, b);
         rx = b;
         rx_tog = ~rx_tog;
      end
      #7 cs_n = 1'b1;
      si = ~si;
      // long gap so the core sees the rise
      #200;
   endtask : frame
endmodule : flash_host_model
`default_nettype wire

//--- test/flash_status_config_regs_test.sv
// self-checking bench for the flash status and configuration register bank
`timescale 1ns/1ns
`default_nettype none
`include "flash_regs_consts.svh"
module flash_status_config_regs_test
   import flash_regs_pkg::*;
;
   // identity values are arbitrary
   localparam logic [7:0] MK = 8'h1E;
   localparam logic [7:0] MT = 8'h2D;
   localparam logic [7:0] DN = 8'h4B;
   localparam logic [7:0] DV = 8'h78;
   logic CLK = 1'b0;
   logic RESETN = 1'b0;
   logic WP_N = 1'b1;
   logic SCLK, CS_N, SI, SO, SO_OE, BUSY, WRITE_ENABLED, HW_PROTECT, QUAD_IO, HIGH_PERF;
   logic [3:0] DUMMY_DUAL, DUMMY_QUAD, lvl;
   logic [7:0] rx, op;
   logic rx_tog;
   logic [7:0] exp_q[$];
   int mismatches = 0;
   int n_compared = 0;
   always #10 CLK = ~CLK;
   flash_host_model host (.sclk(SCLK), .cs_n(CS_N), .si(SI), .so(SO), .rx(rx),
      .rx_tog(rx_tog));
   flash_status_config_regs #(.WSR_CYCLES(200), .PROGRAM_CYCLES(200), .ERASE_CYCLES(200),
      .MAKER_ID(MK), .MEM_TYPE(MT), .DENSITY(DN), .DEVICE_ID(DV)) dut (.CLK(CLK),
      .RESETN(RESETN), .SCLK(SCLK), .CS_N(CS_N), .SI(SI), .WP_N(WP_N), .SO(SO),
      .SO_OE(SO_OE), .BUSY(BUSY), .WRITE_ENABLED(WRITE_ENABLED), .HW_PROTECT(HW_PROTECT),
      .QUAD_IO(QUAD_IO), .HIGH_PERF(HIGH_PERF), .DUMMY_DUAL(DUMMY_DUAL),
      .DUMMY_QUAD(DUMMY_QUAD));
   // ==========================================
   // checking
   task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, e, g);
      end
   endtask : check
   always @(rx_tog)
      if (exp_q.size() != 0)
      begin
         check("so enable", 8'h01, {7'h0, SO_OE});
         check("so byte", exp_q.pop_front(), rx);
      end
   task automatic give_verdict;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : give_verdict
   // ==========================================
   // link helpers
   task automatic rd(input logic [31:0] tx, input int n_tx, input logic [31:0] e, input int n);
      for (int i = 0; i < n; i++)
         exp_q.push_back(e[31-8*i -: 8]);
      host.frame(tx, n_tx, n);
   endtask : rd
   task automatic rs(input logic [7:0] st);
      rd({`READ_STATUS_CMD, 24'h0}, 1, {st, 24'h0}, 1);
   endtask : rs
   task automatic write_enable_cmd;
      host.frame({`WRITE_ENABLE_CMD, 24'h0}, 1, 0);
      check("so enable", 8'h00, {7'h0, SO_OE});
   endtask : write_enable_cmd
   task automatic wait_idle;
      for (int i = 0; i < 1000 && BUSY !== 1'b0; i++)
         @(posedge CLK);
      check("busy", 8'h00, {7'h0, BUSY});
   endtask : wait_idle
   initial
   begin
      #200000;
      mismatches++;
      give_verdict();
   end
   // ==========================================
   // scenarios
   initial
   begin
      void'($urandom(75));
      lvl = 4'(1 + $urandom % 6);
      repeat (10) @(posedge CLK);
      RESETN <= 1'b1;
      repeat (3) @(posedge CLK);
      check("dummy dual", 8'h04, {4'h0, DUMMY_DUAL});
      check("dummy quad", 8'h06, {4'h0, DUMMY_QUAD});
      check("quad io", 8'h00, {7'h0, QUAD_IO});
      rs(`STATUS_RESET);
      host.frame({`PAGE_PROGRAM_CMD, 24'h03F000}, 4, 0);
      rs(8'h00);
      write_enable_cmd();
      rs(8'h02);
      check("write enabled", 8'h01, {7'h0, WRITE_ENABLED});
      // low bits of the status byte must not land in busy or latch
      host.frame({`WRITE_STATUS_CMD, 2'b00, lvl, 2'b11, 8'hFF, 8'hFF}, 4, 0);
      rs({2'b00, lvl, 2'b11});
      wait_idle();
      rs({2'b00, lvl, 2'b00});
      rd({`READ_CONFIG_CMD, 24'h0}, 1, 32'h4802_4800, 3);
      check("dummy dual", 8'h08, {4'h0, DUMMY_DUAL});
      check("dummy quad", 8'h0A, {4'h0, DUMMY_QUAD});
      check("high perf", 8'h01, {7'h0, HIGH_PERF});
      // bottom origin: address zero lies in the protected area
      for (int i = 0; i < 5; i++)
      begin
         op = i == 0 ? `PAGE_PROGRAM_CMD : i == 1 ? `SMALL_AREA_WIPE_CMD :
            i == 2 ? `HALF_BLOCK_WIPE_CMD : i == 3 ? `FULL_BLOCK_WIPE_CMD : `CHIP_WIPE_CMD;
         write_enable_cmd();
         host.frame({op, 24'h000000}, i == 4 ? 1 : 4, 0);
         rs({2'b00, lvl, 2'b00});
      end
      write_enable_cmd();
      host.frame({`PAGE_PROGRAM_CMD, 24'h03F000}, 4, 0);
      rs({2'b00, lvl, 2'b11});
      wait_idle();
      rs({2'b00, lvl, 2'b00});
      rd({`READ_JEDEC_ID_CMD, 24'h0}, 1, {MK, MT, DN, MK}, 4);
      for (int a = 0; a < 2; a++)
         rd({`READ_MAKER_DEVICE_ID_CMD, 16'h0, 8'(a)}, 4,
            a == 0 ? {MK, DV, MK, DV} : {DV, MK, DV, MK}, 4);
      write_enable_cmd();
      host.frame({`WRITE_STATUS_CMD, 2'b10, lvl, 2'b00, 16'h0}, 2, 0);
      wait_idle();
      @(posedge CLK) WP_N <= 1'b0;
      repeat (6) @(posedge CLK);
      check("hw protect", 8'h01, {7'h0, HW_PROTECT});
      write_enable_cmd();
      host.frame({`WRITE_STATUS_CMD, 8'h00, 16'h0}, 2, 0);
      rs({2'b10, lvl, 2'b10});
      @(posedge CLK) WP_N <= 1'b1;
      repeat (6) @(posedge CLK);
      check("hw protect", 8'h00, {7'h0, HW_PROTECT});
      host.frame({`WRITE_DISABLE_CMD, 24'h0}, 1, 0);
      rs({2'b10, lvl, 2'b00});
      // quad enable must override the lock with the pin low
      write_enable_cmd();
      host.frame({`WRITE_STATUS_CMD, 2'b11, lvl, 2'b00, 16'h0}, 2, 0);
      wait_idle();
      @(posedge CLK) WP_N <= 1'b0;
      repeat (6) @(posedge CLK);
      check("quad io", 8'h01, {7'h0, QUAD_IO});
      check("hw protect", 8'h00, {7'h0, HW_PROTECT});
      check("pending", 8'h00, 8'(exp_q.size()));
      give_verdict();
   end
endmodule : flash_status_config_regs_test
`default_nettype wire
